// ==== rtl/fsc_i2c_slave.sv ====
// Byte-level I2C slave engine on oversampled SCL and SDA
`timescale 1ns/1ps
`default_nettype none
module fsc_i2c_slave (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Synchronised link
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe,
  // Address answer
  input wire logic rd_ack,
  // User side
  output logic start_pulse,
  output logic stop_pulse,
  output logic hdr_pulse,
  output logic hdr_rd,
  output logic wr_pulse,
  output logic [7:0] wr_byte,
  output logic rd_req,
  input wire logic [7:0] rd_byte,
  output logic nack_pulse
);
  import fsc_pkg::*;
  logic scl_d, sda_d;
  logic [7:0] shreg;
  logic [3:0] bitn;
  logic in_hdr, active, rd_mode, ack_ph, master_ack;
  logic scl_rise, scl_fall;
  assign scl_rise = scl && !scl_d;
  assign scl_fall = !scl && scl_d;
  // ****************************************
  // Bit and byte framing
  // ****************************************
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      shreg <= 8'h00;
      bitn <= 4'h0;
      in_hdr <= 1'b0;
      active <= 1'b0;
      rd_mode <= 1'b0;
      ack_ph <= 1'b0;
      master_ack <= 1'b0;
      sda_oe <= 1'b0;
      start_pulse <= 1'b0;
      stop_pulse <= 1'b0;
      hdr_pulse <= 1'b0;
      hdr_rd <= 1'b0;
      wr_pulse <= 1'b0;
      wr_byte <= 8'h00;
      rd_req <= 1'b0;
      nack_pulse <= 1'b0;
    end
    else
    begin
      scl_d <= scl;
      sda_d <= sda;
      start_pulse <= 1'b0;
      stop_pulse <= 1'b0;
      hdr_pulse <= 1'b0;
      wr_pulse <= 1'b0;
      rd_req <= 1'b0;
      nack_pulse <= 1'b0;
      if (scl && scl_d && sda_d && !sda)
      begin
        // Start or repeated start
        start_pulse <= 1'b1;
        in_hdr <= 1'b1;
        active <= 1'b1;
        rd_mode <= 1'b0;
        ack_ph <= 1'b0;
        // All ones: the start's own SCL fall wraps it to zero, else bytes run short
        bitn <= 4'hF;
        sda_oe <= 1'b0;
      end
      else if (scl && scl_d && !sda_d && sda)
      begin
        // Stop releases the bus whatever the phase
        stop_pulse <= 1'b1;
        active <= 1'b0;
        sda_oe <= 1'b0;
      end
      else if (active && scl_rise)
      begin
        if (ack_ph)
          master_ack <= !sda;
        else if (!rd_mode)
          shreg <= {shreg[6:0], sda};
      end
      else if (active && scl_fall)
      begin
        if (ack_ph)
        begin
          ack_ph <= 1'b0;
          bitn <= 4'h0;
          if (rd_mode && sda_oe == 1'b0 && master_ack)
          begin
            // Master acked: present next byte
            rd_req <= 1'b1;
            sda_oe <= !rd_byte[7];
            shreg <= {rd_byte[6:0], 1'b0};
          end
          else if (rd_mode && !master_ack)
          begin
            // Master NACK ends the read; stay off the line
            nack_pulse <= 1'b1;
            active <= 1'b0;
            sda_oe <= 1'b0;
          end
          else
            sda_oe <= 1'b0;
        end
        else if (bitn == 4'd7 && !rd_mode)
        begin
          bitn <= 4'h0;
          if (in_hdr)
          begin
            in_hdr <= 1'b0;
            if (shreg[7:1] == FSC_ADDR && (!shreg[0] || rd_ack))
            begin
              hdr_pulse <= 1'b1;
              hdr_rd <= shreg[0];
              sda_oe <= 1'b1;
              ack_ph <= 1'b1;
              master_ack <= 1'b0;
            end
            else
              active <= 1'b0; // Wrong address or read NACKed
          end
          else
          begin
            wr_pulse <= 1'b1;
            wr_byte <= shreg;
            sda_oe <= 1'b1;
            ack_ph <= 1'b1;
          end
        end
        else if (bitn == 4'd7 && rd_mode)
        begin
          sda_oe <= 1'b0;
          ack_ph <= 1'b1;
          master_ack <= 1'b0;
        end
        else if (rd_mode)
        begin
          bitn <= bitn + 4'd1;
          sda_oe <= !shreg[7];
          shreg <= {shreg[6:0], 1'b0};
        end
        else
        begin
          bitn <= bitn + 4'd1;
          if (in_hdr == 1'b0 && bitn == 4'd0 && sda_oe)
            sda_oe <= 1'b0;
        end
        // Header ack finished in read mode: first data byte
        if (ack_ph && hdr_rd && !rd_mode && sda_oe)
        begin
          rd_mode <= 1'b1;
          rd_req <= 1'b1;
          sda_oe <= !rd_byte[7];
          shreg <= {rd_byte[6:0], 1'b0};
        end
      end
    end
  end
endmodule // fsc_i2c_slave
`default_nettype wire

// ==== rtl/fsc_pkg.sv ====
// Package of constants and types for the flow sensor command port
package fsc_pkg;
  // ****************************************
  // Link and command constants
  // ****************************************
  localparam logic [6:0] FSC_ADDR = 7'h08;
  localparam logic [15:0] FSC_CMD_WATER = 16'h3608;
  localparam logic [15:0] FSC_CMD_ALCOHOL = 16'h3615;
  localparam logic [15:0] FSC_CMD_STOP = 16'h3FF9;
  localparam logic [7:0] FSC_CRC_POLY = 8'h31;
  localparam logic [7:0] FSC_CRC_INIT = 8'hFF;
  localparam int FSC_BYTES_PER_SET = 9;
  // Flag field positions
  localparam int FSC_FLAG_AIR = 0;
  localparam int FSC_FLAG_HIGH = 1;
  localparam int FSC_FLAG_SMOOTH = 5;
  // ****************************************
  // Timing
  // ****************************************
  localparam int FSC_CLK_MHZ = 250;
  localparam int FSC_FIRST_US = 12000;
  localparam int FSC_STOP_US = 500;
  localparam int FSC_SAMPLE_US = 500;
  localparam int FSC_FIRST_CYC = FSC_FIRST_US * FSC_CLK_MHZ;
  localparam int FSC_STOP_CYC = FSC_STOP_US * FSC_CLK_MHZ;
  localparam int FSC_SAMPLE_CYC = FSC_SAMPLE_US * FSC_CLK_MHZ;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    FSC_IDLE = 2'b00,
    FSC_WARM = 2'b01,
    FSC_MEAS = 2'b10,
    FSC_STOPPING = 2'b11
  } fsc_mode_t;
  typedef struct packed {
    logic [15:0] flow;
    logic [15:0] temp;
    logic [15:0] flags;
  } fsc_set_t;
  typedef struct packed {
    logic air;
    logic high;
    logic smooth;
  } fsc_evt_t;
  // CRC-8 step over one byte
  function automatic logic [7:0] fsc_crc_byte(input logic [7:0] crc, input logic [7:0] b);
    logic [7:0] c;
    c = crc ^ b;
    for (int i = 0; i < 8; i++)
    begin
      c = c[7] ? ((c << 1) ^ FSC_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction
endpackage

// ==== rtl/fsc_sync.sv ====
// Two-flop synchroniser for the link pins
`timescale 1ns/1ps
`default_nettype none
module fsc_sync (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Data
  input wire logic din,
  output logic dout
);
  logic meta;
  // Both flops reset high to match an idle pulled-up line
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      meta <= 1'b1;
      dout <= 1'b1;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // fsc_sync
`default_nettype wire

// ==== rtl/fsc_top.sv ====
// Flow sensor command port: command decode, measurement state and readout
`timescale 1ns/1ps
`default_nettype none
module fsc_top #(
  parameter int FIRST_CYC = fsc_pkg::FSC_FIRST_CYC,
  parameter int STOP_CYC = fsc_pkg::FSC_STOP_CYC,
  parameter int SAMPLE_CYC = fsc_pkg::FSC_SAMPLE_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // I2C pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Measurement core side
  input wire fsc_pkg::fsc_set_t meas_in,
  input wire fsc_pkg::fsc_evt_t evt_in,
  // Status
  output logic measuring,
  output logic heater_on,
  output logic alcohol_cal,
  output logic sample_tick
);
  import fsc_pkg::*;
  logic scl_s, sda_s, eng_oe;
  logic start_p, stop_p, hdr_p, hdr_rd, wr_p, rd_req, nack_p;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;
  logic [7:0] next_rd_byte;
  fsc_mode_t mode;
  logic [31:0] timer;
  logic [31:0] samp_cnt;
  logic data_ready;
  logic [7:0] cmd_hi;
  logic cmd_half;
  logic [15:0] cmd;
  logic cmd_valid;
  logic air_st, high_st;
  fsc_set_t snap;
  logic [3:0] byte_idx;
  logic [7:0] crc;

  // ****************************************
  // Pin synchronisers and link engine
  // ****************************************
  fsc_sync u_sync_scl (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .din(scl_in),
    .dout(scl_s)
  );
  fsc_sync u_sync_sda (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .din(sda_in),
    .dout(sda_s)
  );
  fsc_i2c_slave u_slave (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .scl(scl_s),
    .sda(sda_s),
    .sda_oe(eng_oe),
    .rd_ack(data_ready),
    .start_pulse(start_p),
    .stop_pulse(stop_p),
    .hdr_pulse(hdr_p),
    .hdr_rd(hdr_rd),
    .wr_pulse(wr_p),
    .wr_byte(wr_byte),
    .rd_req(rd_req),
    .rd_byte(rd_byte),
    .nack_pulse(nack_p)
  );

  // Open-drain: output is always low, enable carries the data
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end
    else
    begin
      sda_out <= 1'b0;
      sda_oe <= eng_oe;
    end
  end

  // ****************************************
  // Command assembly
  // ****************************************
  // Two written bytes form one code, high byte first
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      cmd_hi <= 8'h00;
      cmd_half <= 1'b0;
      cmd <= 16'h0000;
      cmd_valid <= 1'b0;
    end
    else
    begin
      cmd_valid <= 1'b0;
      if (hdr_p || start_p)
        cmd_half <= 1'b0;
      else if (wr_p && !cmd_half)
      begin
        cmd_hi <= wr_byte;
        cmd_half <= 1'b1;
      end
      else if (wr_p && cmd_half)
      begin
        cmd <= {cmd_hi, wr_byte};
        cmd_valid <= 1'b1;
        cmd_half <= 1'b0;
      end
    end
  end

  // ****************************************
  // Measurement mode
  // ****************************************
  // Only stop is honoured while running; others ignored
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      mode <= FSC_IDLE;
      timer <= 32'h00000000;
      alcohol_cal <= 1'b0;
      data_ready <= 1'b0;
    end
    else
    begin
      case (mode)
        FSC_IDLE:
        begin
          data_ready <= 1'b0;
          if (cmd_valid && (cmd == FSC_CMD_WATER || cmd == FSC_CMD_ALCOHOL))
          begin
            mode <= FSC_WARM;
            alcohol_cal <= (cmd == FSC_CMD_ALCOHOL);
            timer <= 32'h00000000;
          end
        end
        FSC_WARM, FSC_MEAS:
        begin
          if (cmd_valid && cmd == FSC_CMD_STOP)
          begin
            mode <= FSC_STOPPING;
            data_ready <= 1'b0;
            timer <= 32'h00000000;
          end
          else if (mode == FSC_WARM)
          begin
            timer <= timer + 32'h00000001;
            if (timer == 32'(FIRST_CYC - 1))
            begin
              mode <= FSC_MEAS;
              data_ready <= 1'b1;
            end
          end
        end
        FSC_STOPPING:
        begin
          // Commands arriving during power-down are dropped
          timer <= timer + 32'h00000001;
          if (timer == 32'(STOP_CYC - 1))
            mode <= FSC_IDLE;
        end
        default:
          mode <= FSC_IDLE;
      endcase
    end
  end

  // Status pins
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      measuring <= 1'b0;
      heater_on <= 1'b0;
    end
    else
    begin
      measuring <= (mode == FSC_MEAS) || (mode == FSC_WARM);
      heater_on <= (mode == FSC_MEAS) || (mode == FSC_WARM);
    end
  end

  // ****************************************
  // Sample pacing
  // ****************************************
  // One-cycle tick every sample period while in FSC_MEAS to the averaging core
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      samp_cnt <= 32'h00000000;
      sample_tick <= 1'b0;
    end
    else
    begin
      sample_tick <= 1'b0;
      if (mode != FSC_MEAS)
        samp_cnt <= 32'h00000000;
      else if (samp_cnt == 32'(SAMPLE_CYC - 1))
      begin
        samp_cnt <= 32'h00000000;
        sample_tick <= 1'b1;
      end
      else
        samp_cnt <= samp_cnt + 32'h00000001;
    end
  end

  // ****************************************
  // Sticky event flags
  // ****************************************
  // Cleared when the flag low byte goes out; a new event wins
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      air_st <= 1'b0;
      high_st <= 1'b0;
    end
    else
    begin
      if (evt_in.air)
        air_st <= 1'b1;
      else if (rd_req && byte_idx == 4'd7)
        air_st <= 1'b0;
      if (evt_in.high)
        high_st <= 1'b1;
      else if (rd_req && byte_idx == 4'd7)
        high_st <= 1'b0;
    end
  end

  // ****************************************
  // Readout sequencing
  // ****************************************
  // Snapshot on read header so each read is the latest set
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      snap <= '0;
      byte_idx <= 4'h0;
      crc <= FSC_CRC_INIT;
      rd_byte <= 8'h00;
    end
    else if (hdr_p && hdr_rd)
    begin
      snap.flow <= meas_in.flow;
      snap.temp <= meas_in.temp;
      snap.flags <= 16'h0000; // Reserved bits zero
      snap.flags[FSC_FLAG_AIR] <= air_st | evt_in.air;
      snap.flags[FSC_FLAG_HIGH] <= high_st | evt_in.high;
      snap.flags[FSC_FLAG_SMOOTH] <= evt_in.smooth;
      byte_idx <= 4'h0;
      crc <= FSC_CRC_INIT;
      rd_byte <= meas_in.flow[15:8];
    end
    else if (rd_req)
    begin
      // Nine-byte cycle, wraps if the master keeps reading
      byte_idx <= (byte_idx == 4'(FSC_BYTES_PER_SET - 1)) ? 4'h0 : byte_idx + 4'd1;
      if (byte_idx == 4'd2 || byte_idx == 4'd5 || byte_idx == 4'd8)
        crc <= FSC_CRC_INIT;
      else
        crc <= fsc_crc_byte(crc, rd_byte);
      rd_byte <= next_rd_byte;
    end
  end

  // Byte following the one just sent
  always_comb
  begin
    case (byte_idx)
      4'd0: next_rd_byte = snap.flow[7:0];
      4'd1: next_rd_byte = fsc_crc_byte(crc, rd_byte);
      4'd2: next_rd_byte = snap.temp[15:8];
      4'd3: next_rd_byte = snap.temp[7:0];
      4'd4: next_rd_byte = fsc_crc_byte(crc, rd_byte);
      4'd5: next_rd_byte = snap.flags[15:8];
      4'd6: next_rd_byte = snap.flags[7:0];
      4'd7: next_rd_byte = fsc_crc_byte(crc, rd_byte);
      4'd8: next_rd_byte = snap.flow[15:8];
      default: next_rd_byte = 8'h00;
    endcase
  end
endmodule // fsc_top
`default_nettype wire

// ==== tb/fsc_i2c_master.sv ====
// Behavioural I2C master facing the flow sensor command port
`timescale 1ns/1ps
`default_nettype none
module fsc_i2c_master (
  // Clock
  input wire logic clk_sys,
  // Link
  output logic scl,
  output logic sda_oe,
  input wire logic sda
);
  import fsc_pkg::*;
  logic [7:0] rbuf [0:8];
  // Bus idles released, SCL parked high between frames
  initial
  begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // One quarter of the 80 ns SCL period
  task automatic q();
    repeat (5) @(negedge clk_sys);
  endtask
  // Data set while SCL low, sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    sda_oe = !b;
    q();
    scl = 1'b1;
    q();
    r = sda;
    q();
    scl = 1'b0;
    q();
  endtask
  // Byte MSB first, then ack slot; ab=1 releases the slot
  task automatic byte_io(input logic [7:0] tx, input logic ab, output logic [7:0] rx,
                         output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(ab, r);
    ack = !r;
  endtask
  // Start and stop conditions
  task automatic start_c();
    sda_oe = 1'b1;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic stop_c();
    sda_oe = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_oe = 1'b0;
    q();
  endtask
  // Write header then one whole 16-bit code
  task automatic cmd(input logic [15:0] c);
    logic [7:0] d;
    logic a;
    start_c();
    byte_io({FSC_ADDR, 1'b0}, 1'b1, d, a);
    byte_io(c[15:8], 1'b1, d, a);
    byte_io(c[7:0], 1'b1, d, a);
    stop_c();
  endtask
  // Read header, n bytes, NACK on the last then STOP
  task automatic rd(input int n, output logic ack);
    logic a;
    logic [7:0] d;
    start_c();
    byte_io({FSC_ADDR, 1'b1}, 1'b1, d, ack);
    for (int i = 0; ack && i < n; i++)
    begin
      byte_io(8'hFF, (i == n - 1), rbuf[i], a);
    end
    stop_c();
  endtask
endmodule // fsc_i2c_master
`default_nettype wire

// ==== tb/fsc_top_chk.sv ====
// Concurrent checks on the ports of the flow sensor command port
`timescale 1ns/1ps
`default_nettype none
module fsc_top_chk #(
  parameter int FIRST_CYC = 200,
  parameter int STOP_CYC = 20,
  parameter int SAMPLE_CYC = 20
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // I2C pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Core side
  input wire fsc_pkg::fsc_set_t meas_in,
  input wire fsc_pkg::fsc_evt_t evt_in,
  // Status
  input wire logic measuring,
  input wire logic heater_on,
  input wire logic alcohol_cal,
  input wire logic sample_tick
);
  import fsc_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Gap since last tick; only trusted once a tick was seen in this run
  int tick_gap;
  logic tick_seen;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      tick_gap <= 0;
      tick_seen <= 1'b0;
    end
    else
    begin
      tick_gap <= sample_tick ? 0 : tick_gap + 1;
      tick_seen <= measuring && (sample_tick || tick_seen);
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  a_drive_low: assert property (sda_oe |-> !sda_out)
    else $error("data pin driven high");
  a_heater_follows: assert property (heater_on == measuring)
    else $error("heater and measuring disagree");
  a_cal_held: assert property (measuring && $past(measuring) |-> $stable(alcohol_cal))
    else $error("calibration changed while measuring");
  a_tick_single: assert property (sample_tick |=> !sample_tick)
    else $error("sample tick longer than one cycle");
  a_tick_meas: assert property (sample_tick |-> measuring)
    else $error("sample tick while idle");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data pin changed while clock high");
  a_stop_rest: assert property ($fell(measuring) |=> !measuring [*8])
    else $error("measuring resumed right after stop");
  a_tick_period: assert property (sample_tick && tick_seen |-> tick_gap == SAMPLE_CYC - 1)
    else $error("sample tick period wrong");
endmodule // fsc_top_chk
bind fsc_top fsc_top_chk #(.FIRST_CYC(FIRST_CYC), .STOP_CYC(STOP_CYC),
  .SAMPLE_CYC(SAMPLE_CYC)) u_chk (.clk_sys(clk_sys), .nrst(nrst), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .meas_in(meas_in), .evt_in(evt_in),
  .measuring(measuring), .heater_on(heater_on), .alcohol_cal(alcohol_cal),
  .sample_tick(sample_tick));
`default_nettype wire

// ==== tb/fsc_top_tb.sv ====
// Self-checking testbench for the flow sensor command port
`timescale 1ns/1ps
`default_nettype none
module fsc_top_tb;
  import fsc_pkg::*;
  // Shortened counts keep the run small
  localparam int T_FIRST = 2000;
  localparam int T_STOP = 1000;
  localparam int T_SAMPLE = 20;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic scl_m, m_oe, sda_oe, sda_out, measuring, heater_on, alcohol_cal, sample_tick, ack;
  wire sda_w;
  fsc_set_t meas = '0;
  fsc_evt_t evt = '0;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;
  // Open-drain data line with pull-up
  assign sda_w = !(m_oe || (sda_oe && !sda_out));
  always #2 clk_sys = ~clk_sys;
  fsc_top #(.FIRST_CYC(T_FIRST), .STOP_CYC(T_STOP), .SAMPLE_CYC(T_SAMPLE)) uut (
    .clk_sys(clk_sys), .nrst(nrst), .scl_in(scl_m), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .meas_in(meas), .evt_in(evt), .measuring(measuring),
    .heater_on(heater_on), .alcohol_cal(alcohol_cal), .sample_tick(sample_tick));
  fsc_i2c_master m (.clk_sys(clk_sys), .scl(scl_m), .sda_oe(m_oe), .sda(sda_w));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Bitwise CRC-8 written independently of the design
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 15; i >= 0; i--)
      c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ 8'h31) : {c[6:0], 1'b0};
    return c;
  endfunction
  // Measuring follows a command before STOP; four settling cycles after it
  task automatic cmd(input logic [15:0] c);
    m.cmd(c);
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic rd_chk(input int n, input logic [15:0] fg);
    logic [7:0] e [0:8];
    e = '{meas.flow[15:8], meas.flow[7:0], crc8(meas.flow), meas.temp[15:8],
          meas.temp[7:0], crc8(meas.temp), fg[15:8], fg[7:0], crc8(fg)};
    m.rd(n, ack);
    chk(ack, 1'b1);
    for (int i = 0; i < n; i++)
      chk(m.rbuf[i], e[i]);
    chk(sda_w, 1'b1);
  endtask
  task automatic pulse_evt(input fsc_evt_t v);
    evt = v;
    repeat (4) @(negedge clk_sys);
    evt.air = 1'b0;
    evt.high = 1'b0;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_idle();
    m.rd(9, ack);
    chk(ack, 1'b0);
    cmd(16'h1234);
    chk(measuring, 1'b0);
    $display("test idle done");
  endtask
  task automatic t_water();
    cmd(FSC_CMD_WATER);
    chk({heater_on, measuring, alcohol_cal}, 3'b110);
    m.rd(1, ack);
    chk(ack, 1'b0);
    repeat (T_FIRST) @(negedge clk_sys);
    meas = {16'hBEEF, 16'h1A2B, 16'hFFFF};
    pulse_evt(3'b101);
    rd_chk(9, 16'h0021);
    rd_chk(9, 16'h0020);
    $display("test water done");
  endtask
  task automatic t_reject();
    cmd(FSC_CMD_ALCOHOL);
    cmd(16'h1234);
    chk({measuring, alcohol_cal}, 2'b10);
    pulse_evt(3'b011);
    meas.flow = 16'h8001;
    rd_chk(3, 16'h0022);
    meas.temp = 16'h00FE;
    rd_chk(5, 16'h0022);
    rd_chk(9, 16'h0022);
    rd_chk(9, 16'h0020);
    $display("test reject done");
  endtask
  task automatic t_stop();
    cmd(FSC_CMD_STOP);
    chk({heater_on, measuring}, 2'b00);
    cmd(FSC_CMD_ALCOHOL);
    chk(measuring, 1'b0);
    repeat (T_STOP) @(negedge clk_sys);
    cmd(FSC_CMD_ALCOHOL);
    chk({measuring, alcohol_cal}, 2'b11);
    m.rd(1, ack);
    chk(ack, 1'b0);
    $display("test stop done");
  endtask
  // Hang guard, well above the expected 17k cycles
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 80000)
    begin
      err_total++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (3) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (5) @(negedge clk_sys);
    t_idle();
    t_water();
    t_reject();
    t_stop();
    end_of_test();
  end
endmodule // fsc_top_tb
`default_nettype wire
